// ==== verilog/sram_ctrl_pkg.sv ====
// Package with constants and carriers for the static memory controller.
package sram_ctrl_pkg;

    // ****************************************************************
    // Memory geometry.
    // ****************************************************************
    localparam int ADDR_W     = 12;                 // Address width.
    localparam int WORD_COUNT = 4096;               // Words in the memory.

    // ****************************************************************
    // Timing figures in nanoseconds and derived cycle counts.
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 4;               // Clock period.
    localparam int ACCESS_NS     = 35;              // Address to data valid.
    localparam int STROBE_NS     = 20;              // Strobe low width.
    localparam int DSETUP_NS     = 20;              // Data set-up to end.
    localparam int DHOLD_NS      = 10;              // Data hold after end.
    localparam int ASETUP_NS     = 35;              // Address set-up to end.
    // Least times round up to whole cycles.
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int STROBE_RAW = (ASETUP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_RAW > ((STROBE_NS + DSETUP_NS
                                - STROBE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS)) ? STROBE_RAW
                                : (DSETUP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int HOLD_CYC   = (DHOLD_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int CNT_W      = 4;                  // Timer width.
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;   // Timer reset value.

    // ****************************************************************
    // Carriers.
    // ****************************************************************
    typedef struct packed
    {
        logic              write;                   // One for a write.
        logic [ADDR_W-1:0] addr;                    // Word address.
        logic              data;                    // Write data.
    } req_s;

    typedef struct packed
    {
        logic              selectN;                 // Device select, low.
        logic              strobeN;                 // Write strobe, low.
        logic [ADDR_W-1:0] addr;                    // Address pins.
        logic              dataInPin;               // Data input pin.
    } pins_s;

    localparam pins_s PINS_IDLE = '{selectN: 1'b1, strobeN: 1'b1,
                                   addr: 12'h000, dataInPin: 1'b0};

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,                         // Deselected, standby.
        ST_READ   = 3'b001,                         // Select low, wait.
        ST_WSTRB  = 3'b010,                         // Write overlap.
        ST_WHOLD  = 3'b011,                         // Data hold after end.
        ST_RDONE  = 3'b100                          // Sample read data.
    } state_e;

endpackage

// ==== verilog/sram_ctrl.sv ====
// Controller that drives an asynchronous 4096 by 1 static memory.
`timescale 1ns/1ps
// Operation
// - Select and strobe both low writes data.
// - Select low, strobe high reads word.
// - Write lasts while select and strobe overlap.
// - Hold data stable around terminating edge.
module sram_ctrl
(
    input  wire logic                       clock,      // System clock.
    input  wire logic                       rst_n,      // Reset, low.
    input  wire logic                       reqValid,   // Request offered.
    input  wire sram_ctrl_pkg::req_s        req,        // Request fields.
    output logic                            reqReady,   // Request taken.
    output logic                            rdValid,    // Read data pulse.
    output logic                            rdData,     // Read data.
    output sram_ctrl_pkg::pins_s            pins,       // Memory pins.
    input  wire logic                       dataOutPin  // Memory output.
);
    import sram_ctrl_pkg::*;

    // ****************************************************************
    // State and registers.
    // ****************************************************************
    state_e            state_q;                     // Sequencer state.
    state_e            state_d;                     // Next state.
    logic [CNT_W-1:0]  cnt_q;                       // Cycle timer.
    logic [CNT_W-1:0]  cnt_d;                       // Next timer.
    pins_s             pins_q;                      // Pin drivers.
    pins_s             pins_d;                      // Next pin values.
    logic              ready_q;                     // Ready flop.
    logic              ready_d;                     // Next ready.
    logic              rdValid_q;                   // Read pulse flop.
    logic              rdValid_d;                   // Next read pulse.
    logic              rdData_q;                    // Read data flop.
    logic              rdData_d;                    // Next read data.
    logic              doSync1_q;                   // First sync stage.
    logic              doSync2_q;                   // Second sync stage.

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    // Timer reload value, sized to the counter.
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = n[CNT_W-1:0];
    endfunction

    // ****************************************************************
    // Input synchroniser for the memory data output.
    // ****************************************************************
    // The memory answers without our clock, so two flops precede use.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            doSync1_q <= 1'b0;
            doSync2_q <= 1'b0;
        end
        else
        begin
            doSync1_q <= dataOutPin;
            doSync2_q <= doSync1_q;
        end
    end

    // ****************************************************************
    // Sequencer next-state logic.
    // ****************************************************************
    // Reads wait access time plus two sync cycles before sampling.
    always_comb
    begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        pins_d    = pins_q;
        ready_d   = 1'b0;
        rdValid_d = 1'b0;
        rdData_d  = rdData_q;
        case (state_q)
            ST_IDLE:
            begin
                // Between accesses the select is high for standby.
                pins_d.selectN = 1'b1;
                pins_d.strobeN = 1'b1;
                if (reqValid && !ready_q)
                begin
                    ready_d     = 1'b1;
                    pins_d.addr = req.addr;
                    pins_d.dataInPin = req.data;
                    pins_d.selectN = 1'b0;
                    if (req.write)
                    begin
                        // Both low opens the write overlap.
                        pins_d.strobeN = 1'b0;
                        cnt_d   = cyc(STROBE_CYC - 1);
                        state_d = ST_WSTRB;
                    end
                    else
                    begin
                        // Select low, strobe high drives the output.
                        cnt_d   = cyc(ACCESS_CYC + 1);
                        state_d = ST_READ;
                    end
                end
            end
            ST_READ:
            begin
                // Address held steady; output follows it.
                if (cnt_q == CNT_ZERO)
                begin
                    state_d = ST_RDONE;
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_RDONE:
            begin
                rdData_d       = doSync2_q;
                rdValid_d      = 1'b1;
                pins_d.selectN = 1'b1;
                state_d        = ST_IDLE;
            end
            ST_WSTRB:
            begin
                if (cnt_q == CNT_ZERO)
                begin
                    // Strobe rising ends the overlap; data stays.
                    pins_d.strobeN = 1'b1;
                    cnt_d   = cyc(HOLD_CYC);
                    state_d = ST_WHOLD;
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_WHOLD:
            begin
                // Address and data held past the terminating edge.
                if (cnt_q == CNT_ZERO)
                begin
                    pins_d.selectN = 1'b1;
                    state_d = ST_IDLE;
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default:
            begin
                pins_d  = PINS_IDLE;
                state_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer registers.
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q   <= ST_IDLE;
            cnt_q     <= CNT_ZERO;
            pins_q    <= PINS_IDLE;
            ready_q   <= 1'b0;
            rdValid_q <= 1'b0;
            rdData_q  <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            pins_q    <= pins_d;
            ready_q   <= ready_d;
            rdValid_q <= rdValid_d;
            rdData_q  <= rdData_d;
        end
    end

    assign pins     = pins_q;
    assign reqReady = ready_q;
    assign rdValid  = rdValid_q;
    assign rdData   = rdData_q;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence writeOpen;
        !pins_q.selectN && !pins_q.strobeN;
    endsequence

    sequence writeClose;
        pins_q.strobeN && !pins_q.selectN;
    endsequence

    strobe_width_a: assert property (
        $fell(pins_q.strobeN) |-> writeOpen [*5])
        else $error("Write strobe shorter than required.");

    write_close_a: assert property (
        $rose(pins_q.strobeN) |-> writeClose)
        else $error("Select left before the strobe.");

    data_hold_a: assert property (
        $rose(pins_q.strobeN) |=> $stable(pins_q.dataInPin) [*3])
        else $error("Write data moved within hold time.");

    addr_steady_a: assert property (
        !pins_q.selectN && !$fell(pins_q.selectN)
        |-> $stable(pins_q.addr))
        else $error("Address moved while selected.");

    read_strobe_a: assert property (
        state_q == ST_READ |-> pins_q.strobeN && !pins_q.selectN)
        else $error("Read without select low and strobe high.");

    read_time_a: assert property (
        $rose(ready_q) && state_q == ST_READ
        |-> ##12 rdValid_q)
        else $error("Read sample not at access time.");

    standby_a: assert property (
        state_q == ST_IDLE |-> pins_q.selectN)
        else $error("Select low while idle.");

    float_a: assert property (
        rdValid_q |-> $past(pins_q.strobeN) && !$past(pins_q.selectN))
        else $error("Read sampled while output floats.");

endmodule

// ==== verif/sram_device_model.sv ====
// Behavioural model of the asynchronous 4096 by 1 static memory.
`timescale 1ns/1ps
module sram_device_model
(
    input  wire sram_ctrl_pkg::pins_s pins,       // Pins from controller.
    input  wire logic                 slowMode,   // One for full access.
    output logic                      dataOutPin, // Data output pin.
    output logic                      standby,    // High in low power.
    output logic                      holdFault   // Write inputs moved.
);
    import sram_ctrl_pkg::*;
    logic              memArr [WORD_COUNT]; // Storage cells.
    logic              overlap;             // Internal write interval.
    logic [ADDR_W-1:0] wAddr;               // Address at write start.
    logic              wData;               // Data at write start.
    int                gen;                 // Counts pin changes.

    assign overlap = !pins.selectN && !pins.strobeN;
    assign standby = pins.selectN;
    initial
    begin
        dataOutPin = 1'b0;
        holdFault  = 1'b0;
        gen        = 0;
    end
    // Write inputs are captured where the overlap opens and compared.
    always @(posedge overlap)
    begin
        // Each write is judged on its own, so a write cut by a reset
        // does not taint the writes that follow it.
        holdFault = 1'b0;
        wAddr = pins.addr;
        wData = pins.dataInPin;
    end
    // The cell takes the data when the terminating edge ends the write.
    always @(negedge overlap)
    begin
        if (pins.addr !== wAddr || pins.dataInPin !== wData)
            holdFault = 1'b1;
        memArr[pins.addr] = pins.dataInPin;
    end
    // A released output shows junk; a read word lands after access time with slowMode, after 8 ns without it.
    always @(pins)
    begin
        gen        = gen + 1;
        dataOutPin = ~dataOutPin;
        if (!pins.selectN && pins.strobeN)
            fork
                automatic int myGen = gen;
                begin
                    #(slowMode ? ACCESS_NS : 8);
                    if (myGen == gen)
                        dataOutPin = memArr[pins.addr];
                end
            join_none
    end
endmodule

// ==== verif/sram_ctrl_tb.sv ====
// Self-checking testbench for the static memory controller.
`timescale 1ns/1ps
module sram_ctrl_tb;
    import sram_ctrl_pkg::*;
    // ****************************************************************
    // Wiring and bookkeeping.
    // ****************************************************************
    logic  clock;              // Bench clock.
    logic  rst_n;              // Reset, low.
    logic  reqValid;           // Request offered.
    req_s  req;                // Request fields.
    logic  reqReady;           // Request taken.
    logic  rdValid;            // Read data pulse.
    logic  rdData;             // Read data.
    pins_s pins;               // Memory pins.
    logic  dataOutPin;         // Memory output.
    logic  slowMode;           // Model access speed.
    logic  standby;            // Model low-power flag.
    logic  holdFault;          // Model saw write inputs move.
    logic  shadow [WORD_COUNT]; // Expected contents, unknown if unwritten.
    int    nMismatch;          // Mismatches seen.
    int    checked;            // Comparisons made.

    sram_ctrl u_dut (.clock(clock), .rst_n(rst_n), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .rdValid(rdValid),
        .rdData(rdData), .pins(pins), .dataOutPin(dataOutPin));
    sram_device_model u_mem (.pins(pins), .slowMode(slowMode),
        .dataOutPin(dataOutPin), .standby(standby), .holdFault(holdFault));

    always #2 clock = ~clock;

    // Compares one value and counts the result.
    task automatic check(logic [15:0] seen, logic [15:0] exp, string msg);
        checked++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("Checks made %0d, mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Cycles from the edge after the take until select is seen high
    // again: strobe overlap, data hold, then the deselect edge.
    function automatic int write_len();
        return STROBE_CYC + HOLD_CYC + 1;
    endfunction

    // Cycles from the edge after the take until read data is seen:
    // access wait, two synchroniser stages, then the sample edge.
    function automatic int read_len();
        return ACCESS_CYC + 3;
    endfunction

    // Runs one transfer; called just after a rising edge.
    task automatic do_op(logic wr, logic [ADDR_W-1:0] a, logic d);
        int n;
        n = 0;
        reqValid <= 1'b1;
        req      <= '{write: wr, addr: a, data: d};
        slowMode <= 1'($urandom % 2);
        do begin @(posedge clock); n++; end
        while (reqReady !== 1'b1 && n < 50);
        reqValid <= 1'b0;
        check({pins.selectN, pins.strobeN, pins.addr},
              {1'b0, ~wr, a}, "pins at start");
        n = 0;
        if (wr)
        begin
            check(pins.dataInPin, d, "write data pin");
            do begin @(posedge clock); n++; end
            while (pins.selectN !== 1'b1 && n < 50);
            check(n, write_len(), "write length");
            check(holdFault, 1'b0, "write inputs moved");
            shadow[a] = d;
        end
        else
        begin
            do begin @(posedge clock); n++; end
            while (rdValid !== 1'b1 && n < 50);
            check(n, read_len(), "read latency");
            check(rdData, shadow[a], "read data");
        end
        check(standby, 1'b1, "deselect after op");
    endtask

    // Watchdog against a hang.
    initial
    begin
        #(8000 * CLK_PERIOD_NS);
        nMismatch++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        logic [ADDR_W-1:0] a;
        logic [ADDR_W-1:0] corner [4];
        clock = 1'b0;
        rst_n = 1'b0;
        reqValid = 1'b0;
        req = '0;
        slowMode = 1'b0;
        nMismatch = 0;
        checked = 0;
        corner = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
        foreach (shadow[i]) shadow[i] = 1'bx;
        void'($urandom(32'h7377));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check({pins.selectN, pins.strobeN}, 2'b11, "idle strobes");
        // Corner addresses, both levels, overwrite then read back.
        foreach (corner[i])
            for (int d = 1; d >= 0; d--)
            begin
                do_op(1'b1, corner[i], 1'(d));
                do_op(1'b0, corner[i], 1'bx);
            end
        foreach (corner[i])
            do_op(1'b0, corner[i], 1'bx);
        // Random mix over a small and the whole range.
        repeat (60)
        begin
            a = ($urandom % 2) ? 12'($urandom % 16) : 12'($urandom);
            if (shadow[a] !== 1'bx && ($urandom % 2))
                do_op(1'b0, a, 1'bx);
            else
                do_op(1'b1, a, 1'($urandom));
        end
        // Reset in the middle of a write.
        reqValid <= 1'b1;
        req      <= '{write: 1'b1, addr: 12'h005, data: 1'b1};
        repeat (5) @(posedge clock);
        rst_n    <= 1'b0;
        reqValid <= 1'b0;
        #1;
        check({pins.selectN, pins.strobeN, reqReady, rdValid},
              4'hc, "pins in reset");
        // The cut write ends with the address already at zero.
        shadow[5] = 1'bx;
        shadow[0] = 1'bx;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        do_op(1'b1, 12'h005, 1'b0);
        do_op(1'b0, 12'h005, 1'bx);
        do_op(1'b0, 12'hfff, 1'bx);
        wrap_up();
    end
endmodule
